// ---- shared/bdfd_regs.vh ----
// constants for the branch and dma field decoder
`ifndef BDFD_REGS_VH
`define BDFD_REGS_VH
// ============================================================
// register offsets (byte addresses)
`define BDFD_CTRL_OFF      12'h000
`define BDFD_INSTR_OFF     12'h004
`define BDFD_KIND_OFF      12'h008
`define BDFD_STATUS_OFF    12'h00c
`define BDFD_BRANCH_OFF    12'h010
`define BDFD_DMA_OFF       12'h014
`define BDFD_CRCA_OFF      12'h018
`define BDFD_CRCB_OFF      12'h01c
`define BDFD_CNT_OFF       12'h020
`define BDFD_RLA_OFF       12'h024
`define BDFD_CMP_OFF       12'h028
// ============================================================
// instruction kind codes (kind register bits 3:0)
`define BDFD_K_NONE        4'h0
`define BDFD_K_BF          4'h1
`define BDFD_K_BI          4'h2
`define BDFD_K_BR          4'h3
`define BDFD_K_D1R         4'h4
`define BDFD_K_D1W         4'h5
`define BDFD_K_D2R         4'h6
`define BDFD_K_D2W         4'h7
`define BDFD_K_CMP         4'h8
`define BDFD_K_COMPARE_WITH_PREVIOUS        4'h9
// kind register field positions
`define BDFD_KIND_LINK     4
`define BDFD_KIND_PLUS     5
`define BDFD_KIND_HASCOND  6
// ============================================================
// branch field positions within the instruction word
`define BDFD_SEL_HI        23
`define BDFD_SEL_LO        20
`define BDFD_SENSE_BIT     19
`define BDFD_COP_BIT       18
`define BDFD_NEVER_BIT     17
`define BDFD_CSOV_BIT      16
`define BDFD_CSO_HI        15
`define BDFD_CSO_LO        8
// counter operation codes
`define BDFD_CSO_DRXB      8'he0
`define BDFD_CSO_DRXF      8'he1
`define BDFD_CSO_ITXB      8'hc2
`define BDFD_CSO_ITXF      8'hc3
// ============================================================
// dma field positions
`define BDFD_INC_BIT       26
`define BDFD_BC_HI         26
`define BDFD_BC_PLUS_HI    25
`define BDFD_BC_LO         19
`define BDFD_IBI_BIT       9
`define BDFD_CRCA_BIT      8
`define BDFD_CRCB_BIT      7
`define BDFD_POD_BIT       6
`define BDFD_ST_BIT        5
// ============================================================
// condition thresholds, reset values and the crc polynomial
`define BDFD_TXF_LOW       8'h02
`define BDFD_RXB_HIGH      8'h04
`define BDFD_SEL_LAST      4'he
`define BDFD_CRC_SEED      32'hffffffff
`define BDFD_CRC_POLY      32'h04c11db7
`endif

// ---- design/bdfd_crc32_step.v ----
// one-byte crc-32 update used by both accumulators
`timescale 1ns/100ps
`default_nettype none
`include "bdfd_regs.vh"
module bdfd_crc32_step (
	input  wire [31:0] crcIn,
	input  wire [7:0]  dataIn,
	output wire [31:0] crcOut
);
	// ============================================================
	// bitwise msb-first lfsr, unrolled over the byte by a generate
	wire [31:0] stage [0:8];
	assign stage[0] = crcIn;
	genvar i;
	generate
		for (i = 0; i < 8; i = i + 1) begin : gBit
			wire fb;
			assign fb = stage[i][31] ^ dataIn[7-i];
			assign stage[i+1] = {stage[i][30:0], 1'b0} ^ (fb ? `BDFD_CRC_POLY : 32'h00000000);
		end
	endgenerate
	assign crcOut = stage[8];
endmodule
`default_nettype wire

// ---- design/bdfd_decoder.v ----
// branch and dma instruction field decoder with an apb register port
//
// The implementer's own choices: the APB register port and the address map.
`timescale 1ns/100ps
`default_nettype none
`include "bdfd_regs.vh"
module bdfd_decoder #(
	parameter CNT_W   = 8,
	parameter TX_FULL = 8'h08
) (
	input  wire        mclk,
	input  wire        nrst,
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	input  wire        inboundStatusA,
	input  wire        inboundStatusB,
	input  wire        assignedCell,
	input  wire        cellSchedulerBusy,
	input  wire        commInboundBusy,
	input  wire        commOutboundBusy,
	input  wire [15:0] sparseEvents,
	input  wire        dma1OutBusy,
	input  wire        dma1QueueBusy,
	input  wire        dma2OutBusy,
	input  wire        dma2QueueBusy,
	input  wire        dmaDone,
	input  wire        dmaDataValid,
	input  wire [7:0]  dmaData,
	output wire        branchTaken,
	output wire        slotExecute,
	output wire        linkSave,
	output wire        reservedSel,
	output reg  [7:0]  byteCount,
	output wire        silentTransfer
);
	// ============================================================
	// software-visible registers and internal engine state
	reg  [31:0] instr_r;
	reg  [6:0]  kind_r;
	reg  [31:0] crcA_r;
	reg  [31:0] crcB_r;
	reg  [CNT_W-1:0] receive_busy_count_r;
	reg  [CNT_W-1:0] receive_full_count_r;
	reg  [CNT_W-1:0] transmit_busy_count_r;
	reg  [CNT_W-1:0] transmit_full_count_r;
	reg  [15:0] rla_r;
	reg  [1:0]  cmpPrev_r;
	reg         dmaActive_r;
	reg         dmaOdd_r;
	reg  [3:0]  dmaKind_r;
	reg         dmaInc_r;
	reg         dmaCrcA_r;
	reg         dmaCrcB_r;
	reg         dmaPod_r;
	reg         dmaSilent_r;
	reg         execPulse_r;
	wire [3:0]  kind = kind_r[3:0];
	wire        isBranch = (kind == `BDFD_K_BF) || (kind == `BDFD_K_BI) || (kind == `BDFD_K_BR);
	wire        isDma = (kind >= `BDFD_K_D1R) && (kind <= `BDFD_K_D2W);
	wire        isPort1 = (kind == `BDFD_K_D1R) || (kind == `BDFD_K_D1W);
	// ============================================================
	// condition selection
	wire [3:0] sel = instr_r[`BDFD_SEL_HI:`BDFD_SEL_LO];
	wire       hasCond = kind_r[`BDFD_KIND_HASCOND];
	reg        cond;
	always @* begin
		cond = 1'b0;
		case (sel)
			4'h0: cond = inboundStatusA;
			4'h1: cond = inboundStatusB;
			4'h2: cond = (transmit_full_count_r <= `BDFD_TXF_LOW);
			4'h3: cond = (receive_busy_count_r >= `BDFD_RXB_HIGH);
			4'h4: cond = assignedCell;
			4'h5: cond = cellSchedulerBusy;
			4'h6: cond = commInboundBusy;
			4'h7: cond = commOutboundBusy;
			4'h8: cond = |sparseEvents;
			4'h9: cond = (receive_busy_count_r != {CNT_W{1'b0}});
			4'ha: cond = (transmit_full_count_r == TX_FULL[CNT_W-1:0]);
			4'hb: cond = dma1OutBusy | dma1QueueBusy;
			4'hc: cond = dma2OutBusy | dma2QueueBusy;
			4'hd: cond = dma1QueueBusy;
			4'he: cond = dma2QueueBusy;
			default: cond = 1'b0;
		endcase
	end
	// reserved code is flagged and never taken, rather than guessed at
	assign reservedSel = isBranch & hasCond & (sel > `BDFD_SEL_LAST);
	wire senseOk = instr_r[`BDFD_SENSE_BIT] ? cond : ~cond;
	wire condMet = ~hasCond | (senseOk & ~reservedSel);
	assign branchTaken = isBranch & condMet;
	assign slotExecute = ~isBranch |
		(hasCond ? (condMet | ~instr_r[`BDFD_COP_BIT]) : ~instr_r[`BDFD_NEVER_BIT]);
	assign linkSave = branchTaken & kind_r[`BDFD_KIND_LINK];
	// ============================================================
	// counter operation carried by a branch
	wire [7:0] cso = instr_r[`BDFD_CSO_HI:`BDFD_CSO_LO];
	wire       csoFire = isBranch & instr_r[`BDFD_CSOV_BIT] & execPulse_r;
	wire       opDrxb = csoFire & (cso == `BDFD_CSO_DRXB);
	wire       opDrxf = csoFire & (cso == `BDFD_CSO_DRXF);
	wire       opItxb = csoFire & (cso == `BDFD_CSO_ITXB);
	wire       opItxf = csoFire & (cso == `BDFD_CSO_ITXF);
	// ============================================================
	// dma field decode
	wire       plus = kind_r[`BDFD_KIND_PLUS];
	always @* begin
		if (plus)
			byteCount = {1'b0, instr_r[`BDFD_BC_PLUS_HI:`BDFD_BC_LO]};
		else
			byteCount = instr_r[`BDFD_BC_HI:`BDFD_BC_LO];
	end
	// raw count goes to the engine; odd values only raise a flag
	wire       oddCount = isDma & byteCount[0];
	// plus forms reuse bit 26 for nothing else, so increment stays at bit 26
	wire       incAddr = instr_r[`BDFD_INC_BIT] & plus;
	wire       optCrcA = isPort1 & instr_r[`BDFD_CRCA_BIT];
	wire       optCrcB = isPort1 & instr_r[`BDFD_CRCB_BIT];
	wire       optSilent = isPort1 & instr_r[`BDFD_ST_BIT];
	// internal flag may not be set by software; such words are refused
	wire       ibiErr = isDma & instr_r[`BDFD_IBI_BIT];
	assign silentTransfer = dmaActive_r & dmaSilent_r;
	wire       doneRead = dmaDone & dmaActive_r & dmaPod_r &
		((dmaKind_r == `BDFD_K_D1R) || (dmaKind_r == `BDFD_K_D2R));
	wire       doneWrite = dmaDone & dmaActive_r & dmaPod_r &
		((dmaKind_r == `BDFD_K_D1W) || (dmaKind_r == `BDFD_K_D2W));
	wire [31:0] crcA_nxt;
	wire [31:0] crcB_nxt;
	bdfd_crc32_step uCrcA (
		.crcIn  (crcA_r),
		.dataIn (dmaData),
		.crcOut (crcA_nxt)
	);
	bdfd_crc32_step uCrcB (
		.crcIn  (crcB_r),
		.dataIn (dmaData),
		.crcOut (crcB_nxt)
	);
	// ============================================================
	// compare with previous: current {eq,lt} on a 16-bit pair
	wire [15:0] cmpA = instr_r[31:16];
	wire [15:0] cmpB = instr_r[15:0];
	wire        curEq = (cmpA == cmpB);
	wire        curLt = (cmpA < cmpB);
	// high half decides unless equal, then the earlier low-half result stands
	wire        chainEq = curEq & cmpPrev_r[1];
	wire        chainLt = curLt | (curEq & cmpPrev_r[0]);
	// ============================================================
	// apb slave, zero wait states
	assign pready = 1'b1;
	wire wrEn = psel & penable & pwrite;
	wire rdEn = psel & penable & ~pwrite;
	reg  mapped;
	always @* begin
		if (paddr == `BDFD_CTRL_OFF || paddr == `BDFD_INSTR_OFF || paddr == `BDFD_KIND_OFF)
			mapped = 1'b1;
		else if (paddr == `BDFD_STATUS_OFF || paddr == `BDFD_BRANCH_OFF)
			mapped = 1'b1;
		else if (paddr == `BDFD_DMA_OFF || paddr == `BDFD_CRCA_OFF || paddr == `BDFD_CRCB_OFF)
			mapped = 1'b1;
		else if (paddr == `BDFD_CNT_OFF || paddr == `BDFD_RLA_OFF || paddr == `BDFD_CMP_OFF)
			mapped = 1'b1;
		else
			mapped = 1'b0;
	end
	// a dma start while a dma is running is refused with an error
	wire startWr = wrEn & (paddr == `BDFD_CTRL_OFF) & pwdata[0];
	wire startBad = startWr & isDma & (dmaActive_r | ibiErr);
	assign pslverr = psel & penable & (~mapped | startBad);
	wire execGo = startWr & ~startBad;
	always @(posedge mclk or negedge nrst) begin
		if (!nrst)
			execPulse_r <= 1'b0;
		else
			execPulse_r <= execGo;
	end
	// ============================================================
	// register writes and engine state
	always @(posedge mclk or negedge nrst) begin
		if (!nrst) begin
			instr_r     <= 32'h00000000;
			kind_r      <= 7'h00;
			crcA_r      <= `BDFD_CRC_SEED;
			crcB_r      <= `BDFD_CRC_SEED;
			receive_busy_count_r    <= {CNT_W{1'b0}};
			receive_full_count_r    <= {CNT_W{1'b0}};
			transmit_busy_count_r    <= {CNT_W{1'b0}};
			transmit_full_count_r    <= {CNT_W{1'b0}};
			rla_r       <= 16'h0000;
			cmpPrev_r   <= 2'b00;
			dmaActive_r <= 1'b0;
			dmaOdd_r    <= 1'b0;
			dmaKind_r   <= 4'h0;
			dmaInc_r    <= 1'b0;
			dmaCrcA_r   <= 1'b0;
			dmaCrcB_r   <= 1'b0;
			dmaPod_r    <= 1'b0;
			dmaSilent_r <= 1'b0;
		end else begin
			if (wrEn && paddr == `BDFD_INSTR_OFF)
				instr_r <= pwdata;
			if (wrEn && paddr == `BDFD_KIND_OFF)
				kind_r <= pwdata[6:0];
			if (wrEn && paddr == `BDFD_RLA_OFF)
				rla_r <= pwdata[15:0];
			// crc writes from software lose to an accumulate in the same cycle
			if (dmaActive_r && dmaCrcA_r && dmaDataValid)
				crcA_r <= crcA_nxt;
			else if (wrEn && paddr == `BDFD_CRCA_OFF)
				crcA_r <= pwdata;
			if (dmaActive_r && dmaCrcB_r && dmaDataValid)
				crcB_r <= crcB_nxt;
			else if (wrEn && paddr == `BDFD_CRCB_OFF)
				crcB_r <= pwdata;
			if (wrEn && paddr == `BDFD_CNT_OFF) begin
				receive_busy_count_r <= pwdata[CNT_W-1:0];
				receive_full_count_r <= pwdata[8 +: CNT_W];
				transmit_busy_count_r <= pwdata[16 +: CNT_W];
				transmit_full_count_r <= pwdata[24 +: CNT_W];
			end else begin
				if (opDrxb)
					receive_busy_count_r <= receive_busy_count_r - 1'b1;
				if (opDrxf || doneWrite)
					receive_full_count_r <= receive_full_count_r - 1'b1;
				if (opItxb || doneRead)
					transmit_busy_count_r <= transmit_busy_count_r + 1'b1;
				if (opItxf)
					transmit_full_count_r <= transmit_full_count_r + 1'b1;
			end
			if (execGo && (kind == `BDFD_K_CMP || kind == `BDFD_K_COMPARE_WITH_PREVIOUS))
				cmpPrev_r <= (kind == `BDFD_K_COMPARE_WITH_PREVIOUS) ? {chainEq, chainLt} : {curEq, curLt};
			if (execGo && isDma) begin
				dmaActive_r <= 1'b1;
				dmaOdd_r    <= oddCount;
				dmaKind_r   <= kind;
				dmaInc_r    <= incAddr;
				dmaCrcA_r   <= optCrcA;
				dmaCrcB_r   <= optCrcB;
				dmaPod_r    <= instr_r[`BDFD_POD_BIT];
				dmaSilent_r <= optSilent;
			end else if (dmaActive_r && dmaDone) begin
				dmaActive_r <= 1'b0;
				if (dmaInc_r)
					rla_r <= rla_r + 16'h0001;
			end
		end
	end
	// ============================================================
	// read mux
	always @* begin
		prdata = 32'h00000000;
		if (paddr == `BDFD_INSTR_OFF)
			prdata = instr_r;
		else if (paddr == `BDFD_KIND_OFF)
			prdata = {25'h0000000, kind_r};
		else if (paddr == `BDFD_STATUS_OFF)
			prdata = {26'h0000000, dmaOdd_r, dmaSilent_r, dmaActive_r, cmpPrev_r, 1'b0};
		else if (paddr == `BDFD_BRANCH_OFF)
			prdata = {28'h0000000, reservedSel, linkSave, slotExecute, branchTaken};
		else if (paddr == `BDFD_DMA_OFF)
			prdata = {19'h00000, optSilent, optCrcB, optCrcA, incAddr, oddCount, byteCount};
		else if (paddr == `BDFD_CRCA_OFF)
			prdata = crcA_r;
		else if (paddr == `BDFD_CRCB_OFF)
			prdata = crcB_r;
		else if (paddr == `BDFD_CNT_OFF)
			prdata = {transmit_full_count_r, transmit_busy_count_r, receive_full_count_r, receive_busy_count_r};
		else if (paddr == `BDFD_RLA_OFF)
			prdata = {16'h0000, rla_r};
		else if (paddr == `BDFD_CMP_OFF)
			prdata = {30'h00000000, cmpPrev_r};
		if (!rdEn)
			prdata = 32'h00000000;
	end
endmodule
`default_nettype wire

// ---- verification/bdfd_decoder_monitor.sv ----
// assertion checker for the branch and dma field decoder
`timescale 1ns/100ps
`default_nettype none
`include "bdfd_regs.vh"
module bdfd_decoder_monitor #(
	parameter CNT_W   = 8,
	parameter TX_FULL = 8'h08
) (
	input wire logic        mclk,
	input wire logic        nrst,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pslverr,
	input wire logic        inboundStatusA,
	input wire logic        inboundStatusB,
	input wire logic        assignedCell,
	input wire logic        cellSchedulerBusy,
	input wire logic        commInboundBusy,
	input wire logic        commOutboundBusy,
	input wire logic [15:0] sparseEvents,
	input wire logic        dma1OutBusy,
	input wire logic        dma1QueueBusy,
	input wire logic        dma2OutBusy,
	input wire logic        dma2QueueBusy,
	input wire logic        dmaDone,
	input wire logic        branchTaken,
	input wire logic        slotExecute,
	input wire logic        linkSave,
	input wire logic        reservedSel,
	input wire logic [7:0]  byteCount,
	input wire logic        silentTransfer
);
	logic        wrAcc;
	logic        exec;
	logic [25:0] stat;
	assign wrAcc = psel && penable && pwrite;
	assign exec  = wrAcc && (paddr == `BDFD_CTRL_OFF) && pwdata[0];
	assign stat  = {inboundStatusA, inboundStatusB, assignedCell, cellSchedulerBusy,
		commInboundBusy, commOutboundBusy, sparseEvents, dma1OutBusy, dma1QueueBusy,
		dma2OutBusy, dma2QueueBusy};
	default clocking cb @(posedge mclk); endclocking
	default disable iff (!nrst);
	// ============================================================
	// decode outputs
	property p_res_nottaken; reservedSel |-> !branchTaken; endproperty
	a_res_nottaken: assert property (p_res_nottaken) else $error("reserved code taken");
	property p_bc_hold; !wrAcc |=> $stable(byteCount); endproperty
	a_bc_hold: assert property (p_bc_hold) else $error("byte count moved");
	// counters move one edge after an execute or on a done, so those cycles are excluded
	property p_flag_hold;
		(!wrAcc && !dmaDone && !$past(wrAcc)) ##1 $stable(stat)
			|-> $stable({branchTaken, slotExecute, reservedSel});
	endproperty
	a_flag_hold: assert property (p_flag_hold) else $error("branch flags moved");
	// link follows the taken flag, so status and counter moves are excluded as above
	property p_link_hold;
		(!wrAcc && !dmaDone && !$past(wrAcc)) ##1 $stable(stat) |-> $stable(linkSave);
	endproperty
	a_link_hold: assert property (p_link_hold) else $error("link flag moved");
	property p_link_taken; linkSave |-> branchTaken; endproperty
	a_link_taken: assert property (p_link_taken) else $error("link without branch");
	property p_rst; $rose(nrst) |-> slotExecute && !branchTaken && !silentTransfer; endproperty
	a_rst: assert property (p_rst) else $error("bad state after reset");
	// ============================================================
	// dma outputs
	property p_silent_fall; $fell(silentTransfer) |-> $past(dmaDone); endproperty
	a_silent_fall: assert property (p_silent_fall) else $error("silent ended early");
	property p_silent_rise; $rose(silentTransfer) |-> $past(exec) || $past(exec, 2); endproperty
	a_silent_rise: assert property (p_silent_rise) else $error("silent without start");
	property p_err_access; pslverr |-> psel && penable; endproperty
	a_err_access: assert property (p_err_access) else $error("error outside access");
	c_silent: cover property ($rose(silentTransfer));
	c_res: cover property (reservedSel);
	c_suppress: cover property (!slotExecute && branchTaken);
endmodule
bind bdfd_decoder bdfd_decoder_monitor #(.CNT_W(CNT_W), .TX_FULL(TX_FULL)) i_bdfd_decoder_monitor (
	.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
	.paddr(paddr), .pwdata(pwdata), .pslverr(pslverr), .inboundStatusA(inboundStatusA),
	.inboundStatusB(inboundStatusB), .assignedCell(assignedCell),
	.cellSchedulerBusy(cellSchedulerBusy), .commInboundBusy(commInboundBusy),
	.commOutboundBusy(commOutboundBusy), .sparseEvents(sparseEvents),
	.dma1OutBusy(dma1OutBusy), .dma1QueueBusy(dma1QueueBusy), .dma2OutBusy(dma2OutBusy),
	.dma2QueueBusy(dma2QueueBusy), .dmaDone(dmaDone), .branchTaken(branchTaken),
	.slotExecute(slotExecute), .linkSave(linkSave), .reservedSel(reservedSel),
	.byteCount(byteCount), .silentTransfer(silentTransfer));
`default_nettype wire

// ---- verification/bdfd_tb.sv ----
// self-checking bench for the branch and dma field decoder
`timescale 1ns/100ps
`default_nettype none
`include "bdfd_regs.vh"
module tb;
	localparam integer TXF = 8;
	logic        mclk, nrst, psel, penable, pwrite, pready, pslverr, serr;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rdat, xa, xb;
	logic [5:0]  st;
	logic [3:0]  dq;
	logic [15:0] sp;
	logic [14:0] cv;
	logic        dmaDone, dmaDataValid, branchTaken, slotExecute, linkSave, reservedSel;
	logic        silentTransfer;
	logic [7:0]  dmaData, byteCount;
	integer      nMismatch, nCompared, seed, i, j, txF, rxB, sel, c, tk, kd, ins, cw, rla;
	bdfd_decoder #(.CNT_W(8), .TX_FULL(TXF)) i_bdfd_decoder (
		.mclk(mclk), .nrst(nrst), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.inboundStatusA(st[0]), .inboundStatusB(st[1]), .assignedCell(st[2]),
		.cellSchedulerBusy(st[3]), .commInboundBusy(st[4]), .commOutboundBusy(st[5]),
		.sparseEvents(sp), .dma1OutBusy(dq[0]), .dma1QueueBusy(dq[1]), .dma2OutBusy(dq[2]),
		.dma2QueueBusy(dq[3]), .dmaDone(dmaDone), .dmaDataValid(dmaDataValid),
		.dmaData(dmaData), .branchTaken(branchTaken), .slotExecute(slotExecute),
		.linkSave(linkSave), .reservedSel(reservedSel), .byteCount(byteCount),
		.silentTransfer(silentTransfer));
	initial begin
		mclk = 1'b0;
		forever #50 mclk = ~mclk;
	end
	task giveVerdict;
		if (nMismatch == 0 && nCompared > 0) $display("Test passed");
		else $display("Test failed");
		$finish;
	endtask
	task chk(input logic [31:0] g, input logic [31:0] e);
		nCompared++;
		if (g !== e) begin
			nMismatch++;
			$display("[ERR] %0t got %h expected %h", $time, g, e);
		end
	endtask
	// reference fold of one byte, msb first
	function automatic logic [31:0] crcStep(input logic [31:0] c, input logic [7:0] d);
		integer b;
		logic [31:0] r;
		r = c;
		for (b = 7; b >= 0; b--)
			r = {r[30:0], 1'b0} ^ ((r[31] ^ d[b]) ? `BDFD_CRC_POLY : 32'h00000000);
		return r;
	endfunction
	// ============================================================
	// apb master: one idle cycle after each transfer keeps drivers single per step
	task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		integer k;
		begin
			psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= d;
			@(posedge mclk);
			penable <= 1'b1;
			k = 0;
			do begin
				@(posedge mclk);
				k++;
			end while (pready !== 1'b1 && k < 20);
			rdat = prdata;
			serr = pslverr;
			if (k >= 20) begin
				nMismatch++;
				giveVerdict;
			end
			psel <= 1'b0; penable <= 1'b0;
			@(posedge mclk);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d); apb(1'b1, a, d); endtask
	task rd(input logic [11:0] a); apb(1'b0, a, 32'h0); endtask
	// ============================================================
	// main sequence
	initial begin
		seed = 69; nMismatch = 0; nCompared = 0; nrst = 1'b0; psel = 1'b0; penable = 1'b0;
		pwrite = 1'b0; paddr = 12'h000; pwdata = 32'h0; st = 6'h00; dq = 4'h0; sp = 16'h0;
		dmaDone = 1'b0; dmaDataValid = 1'b0; dmaData = 8'h00;
		repeat (4) @(posedge mclk);
		nrst <= 1'b1;
		@(posedge mclk);
		rd(`BDFD_CRCA_OFF); chk(rdat, 32'hffffffff);
		rd(`BDFD_CRCB_OFF); chk(rdat, 32'hffffffff);
		rd(12'h0fc); chk(serr, 1);
		for (i = 0; i < 80; i++) begin
			st <= $random(seed); dq <= $random(seed);
			sp <= ($random(seed) & 1) ? 16'h0 : $random(seed);
			txF = {$random(seed)} % 11; rxB = {$random(seed)} % 7;
			ins = $random(seed); kd = 1 + {$random(seed)} % 3 + ($random(seed) & 32'h50);
			wr(`BDFD_CNT_OFF, {8'(txF), 16'h1010, 8'(rxB)});
			wr(`BDFD_INSTR_OFF, ins); wr(`BDFD_KIND_OFF, kd);
			cv = {dq[3], dq[1], dq[2] | dq[3], dq[0] | dq[1], txF == TXF, rxB != 0, |sp,
				st[5], st[4], st[3], st[2], rxB >= 4, txF <= 2, st[1], st[0]};
			sel = ins[23:20];
			tk = !kd[6] ? 1 : (sel == 15 ? 0 : (cv[sel] == ins[19]));
			chk(branchTaken, tk);
			chk(reservedSel, kd[6] && sel == 15);
			chk(linkSave, kd[4] && tk);
			chk(slotExecute, kd[6] ? (tk | !ins[18]) : !ins[17]);
		end
		for (i = 0; i < 4; i++) begin
			cw = ({$random(seed)} & 32'h7f7f7f7f) | 32'h10101010;
			c = (i < 2) ? 8'he0 + i : 8'hc0 + i;
			wr(`BDFD_CNT_OFF, cw); wr(`BDFD_INSTR_OFF, 32'h00010000 | (c << 8));
			wr(`BDFD_KIND_OFF, `BDFD_K_BI); wr(`BDFD_CTRL_OFF, 32'h1);
			repeat (2) @(posedge mclk);
			rd(`BDFD_CNT_OFF);
			chk(rdat, cw + (i == 0 ? -1 : i == 1 ? -256 : i == 2 ? 65536 : 16777216));
		end
		for (j = 0; j < 8; j++) begin
			kd = 4 + j % 4 + (j < 4 ? 32 : 0);
			ins = ($random(seed) & 32'h07f80000) | 32'h04000060;
			cw = 32'h40404040; rla = {$random(seed)} & 32'h0ff0;
			wr(`BDFD_RLA_OFF, rla); wr(`BDFD_CNT_OFF, cw);
			wr(`BDFD_INSTR_OFF, ins); wr(`BDFD_KIND_OFF, kd); wr(`BDFD_CTRL_OFF, 32'h1);
			@(posedge mclk);
			chk(silentTransfer, j % 4 < 2);
			chk(byteCount, j < 4 ? ins[25:19] : ins[26:19]);
			dmaDone <= 1'b1;
			@(posedge mclk);
			dmaDone <= 1'b0;
			@(posedge mclk);
			chk(silentTransfer, 0);
			rd(`BDFD_RLA_OFF); chk(rdat, rla + (j < 4));
			rd(`BDFD_CNT_OFF); chk(rdat, j % 2 ? cw - 32'h100 : cw + 32'h10000);
		end
		// crc folding: port 1 uses its own pair, port 2 ignores the options
		for (i = 0; i < 3; i++) begin
			xa = $random(seed);
			xb = $random(seed);
			wr(`BDFD_CRCA_OFF, xa);
			wr(`BDFD_CRCB_OFF, xb);
			wr(`BDFD_INSTR_OFF, (i == 1) ? 32'h00000080 : 32'h00000100);
			wr(`BDFD_KIND_OFF, (i == 2) ? `BDFD_K_D2W : `BDFD_K_D1W);
			wr(`BDFD_CTRL_OFF, 32'h1);
			for (j = 0; j < 5; j++) begin
				dmaData <= 8'($random(seed));
				dmaDataValid <= 1'b1;
				@(posedge mclk);
				if (i == 0)
					xa = crcStep(xa, dmaData);
				else if (i == 1)
					xb = crcStep(xb, dmaData);
			end
			dmaDataValid <= 1'b0;
			dmaDone <= 1'b1;
			@(posedge mclk);
			dmaDone <= 1'b0;
			rd(`BDFD_CRCA_OFF);
			chk(rdat, xa);
			rd(`BDFD_CRCB_OFF);
			chk(rdat, xb);
		end
		// two-step compare of 32-bit values, low halves first
		for (j = 0; j < 6; j++) begin
			xa = $random(seed);
			xb = (j % 2) ? (xa ^ (32'($random(seed)) & 32'h0000ffff)) : 32'($random(seed));
			if (j == 4)
				xb = xa;
			wr(`BDFD_INSTR_OFF, {xa[15:0], xb[15:0]});
			wr(`BDFD_KIND_OFF, `BDFD_K_CMP);
			wr(`BDFD_CTRL_OFF, 32'h1);
			wr(`BDFD_INSTR_OFF, {xa[31:16], xb[31:16]});
			wr(`BDFD_KIND_OFF, `BDFD_K_COMPARE_WITH_PREVIOUS);
			wr(`BDFD_CTRL_OFF, 32'h1);
			rd(`BDFD_CMP_OFF);
			chk(rdat, {xa == xb, xa < xb});
		end
		wr(`BDFD_INSTR_OFF, 32'h00000220); wr(`BDFD_KIND_OFF, `BDFD_K_D1R);
		wr(`BDFD_CTRL_OFF, 32'h1); chk(serr, 1);
		chk(silentTransfer, 0);
		giveVerdict;
	end
endmodule
`default_nettype wire
